// file: rie_pkg.sv
// constants, instruction formats and types of the risc8 execute core
// How it works
// - add registers, optional carry, full flags
// - subtract register or constant, optional carry
// - and/or update only zero, negative, overflow, sign
// - clear-bits ands with ff minus mask
// - zero-or-minus test keeps register value
// - compare immediate sets flags, no writeback
// - equal registers skip next instruction
// - register bit test skips next instruction
// - i/o bit test skips next instruction
// - flag branch goes to pc+offset+1
// - unsigned branches follow the carry flag
// - signed ge branch when n xor v clear
// - signed lt branch when n xor v set
// - irq branches follow global enable flag
// - i/o bit set/clear, two cycles, flags kept unless the cpu_flags address is the target
// - rotates move carry through, update flags
// - bit store copies bit into transfer flag
// - bit load copies transfer flag into bit
// - half-carry set and clear alone
// - overflow set and clear alone
// - one instruction per 16-bit word
// - prefetch next word during execute
package rie_pkg;
  // program counter and reset values
  localparam int         PC_W      = 9;
  localparam logic [8:0] PC_RST    = 9'h000;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  // cpu_flags sits at this i/o address, served inside the core
  localparam logic [5:0] IO_FLAGS  = 6'h3f;
  localparam logic [7:0] MASK_FF   = 8'hff;
  // cpu_flags bit positions
  localparam logic [2:0] FC = 3'h0;
  localparam logic [2:0] FZ = 3'h1;
  localparam logic [2:0] FN = 3'h2;
  localparam logic [2:0] FV = 3'h3;
  localparam logic [2:0] FS = 3'h4;
  localparam logic [2:0] FH = 3'h5;
  localparam logic [2:0] FT = 3'h6;
  localparam logic [2:0] FI = 3'h7;
  // flags written by each operation class
  localparam logic [7:0] M_ARITH = 8'h3f;
  localparam logic [7:0] M_LOGIC = 8'h1e;
  localparam logic [7:0] M_ROT   = 8'h1f;
  // second register group minor codes
  localparam logic [1:0] RR2_AND  = 2'h0;
  localparam logic [1:0] RR2_OR   = 2'h1;
  localparam logic [1:0] RR2_CPSK = 2'h2;
  // bit group minor codes
  localparam logic [2:0] BT_SKIP_REG_BIT_CLEAR = 3'h0;
  localparam logic [2:0] BT_SKIP_REG_BIT_SET   = 3'h1;
  localparam logic [2:0] BT_STORE_BIT_TO_FLAG  = 3'h2;
  localparam logic [2:0] BT_LOAD_BIT_FROM_FLAG = 3'h3;
  localparam logic [2:0] BT_UNARY              = 3'h4;
  localparam logic [2:0] BT_FLAG_OP            = 3'h5;
  // unary selectors, in the bit field
  localparam logic [2:0] UN_ROTATE_LEFT_CARRY  = 3'h0;
  localparam logic [2:0] UN_ROTATE_RIGHT_CARRY = 3'h1;
  localparam logic [2:0] UN_ZERO_MINUS_CHECK   = 3'h2;
  // i/o group minor codes
  localparam logic [1:0] IO_SKIP_IO_BIT_CLEAR = 2'h0;
  localparam logic [1:0] IO_SKIP_IO_BIT_SET   = 2'h1;
  localparam logic [1:0] IO_SET_IO_BIT        = 2'h2;
  localparam logic [1:0] IO_CLEAR_IO_BIT      = 2'h3;
  // major opcode, top four bits of every word
  typedef enum logic [3:0] {
    OP_RR       = 4'h0,
    OP_RR2      = 4'h1,
    OP_SUBI     = 4'h2,
    OP_MCC      = 4'h3,
    OP_CONJ     = 4'h4,
    OP_DISJ     = 4'h5,
    OP_CLR_MASK = 4'h6,
    OP_CMP_IMM  = 4'h7,
    OP_BIT      = 4'h8,
    OP_IO       = 4'h9,
    OP_BRF      = 4'ha,
    OP_LDI      = 4'hb,
    OP_RJMP     = 4'hc
  } rie_major_t;
  // alu operations; codes 0..3 equal the OP_RR minor field
  typedef enum logic [2:0] {
    ALU_ADD = 3'h0,
    ALU_ADC = 3'h1,
    ALU_SUB = 3'h2,
    ALU_SBC = 3'h3,
    ALU_AND = 3'h4,
    ALU_OR  = 3'h5,
    ALU_ROL = 3'h6,
    ALU_ROR = 3'h7
  } rie_alu_op_t;
  // instruction formats, msb first
  typedef struct packed {
    rie_major_t maj; logic [1:0] mn; logic [4:0] rd; logic [4:0] rr;
  } rie_fmt_rr_t;
  typedef struct packed {
    rie_major_t maj; logic [3:0] rd; logic [7:0] k;
  } rie_fmt_im_t;
  typedef struct packed {
    rie_major_t maj; logic [2:0] mn; logic rsv; logic [4:0] rg;
    logic [2:0] bt;
  } rie_fmt_bit_t;
  typedef struct packed {
    rie_major_t maj; logic [1:0] mn; logic rsv; logic [5:0] addr;
    logic [2:0] bt;
  } rie_fmt_io_t;
  typedef struct packed {
    rie_major_t maj; logic rsv; logic set; logic [6:0] k;
    logic [2:0] sel;
  } rie_fmt_br_t;
  typedef struct packed {
    rie_major_t maj; logic [11:0] k;
  } rie_fmt_jp_t;
endpackage

// file: rie_alu.sv
`timescale 1ns/1ps
// eight-bit alu with flags in cpu_flags layout
module rie_alu (
  // operation select
  input  wire rie_pkg::rie_alu_op_t op,
  // operands and carry in
  input  wire logic [7:0]           a,
  input  wire logic [7:0]           b,
  input  wire logic                 cin,
  // result and flags
  output logic [7:0]                res,
  output logic [7:0]                fl
);
  logic [8:0] w;
  logic       h;
  logic       v;
  logic       n;

  // result with carry in bit 8, then per-class h and v
  always_comb begin
    w = 9'h000;
    h = 1'b0;
    v = 1'b0;
    n = 1'b0;
    unique case (op)
      rie_pkg::ALU_ADD,
      rie_pkg::ALU_ADC: begin
        w = {1'b0, a} + {1'b0, b} + {8'h00, cin & op[0]};
        h = (a[3] & b[3]) | (b[3] & ~w[3]) | (~w[3] & a[3]);
        v = (a[7] & b[7] & ~w[7]) | (~a[7] & ~b[7] & w[7]);
      end
      rie_pkg::ALU_SUB,
      rie_pkg::ALU_SBC: begin
        w = {1'b0, a} - {1'b0, b} - {8'h00, cin & op[0]};
        h = (~a[3] & b[3]) | (b[3] & w[3]) | (w[3] & ~a[3]);
        v = (a[7] & ~b[7] & ~w[7]) | (~a[7] & b[7] & w[7]);
      end
      rie_pkg::ALU_AND: w = {1'b0, a & b};
      rie_pkg::ALU_OR:  w = {1'b0, a | b};
      // carry enters one end, the far bit leaves into carry
      rie_pkg::ALU_ROL: begin
        w = {a[7], a[6:0], cin};
        v = w[7] ^ w[8];
      end
      rie_pkg::ALU_ROR: begin
        w = {a[0], cin, a[7:1]};
        v = w[7] ^ w[8];
      end
    endcase
    n   = w[7];
    res = w[7:0];
    fl  = 8'h00;
    fl[rie_pkg::FC] = w[8];
    fl[rie_pkg::FZ] = (w[7:0] == 8'h00);
    fl[rie_pkg::FN] = n;
    fl[rie_pkg::FV] = v;
    fl[rie_pkg::FS] = n ^ v;
    fl[rie_pkg::FH] = h;
  end
endmodule

// file: rie_core.sv
`timescale 1ns/1ps
// risc8 fetch, decode and execute core
module rie_core (
  // clock and synchronous reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // program memory fetch, data valid in the same cycle
  output logic [8:0]       pm_addr,
  input  wire logic [15:0] pm_data,
  // i/o register space
  output logic [5:0]       io_addr,
  output logic             io_re,
  output logic             io_we,
  output logic [7:0]       io_wdata,
  input  wire logic [7:0]  io_rdata,
  // status and register view
  output logic [7:0]       cpu_flags,
  input  wire logic [4:0]  dbg_sel,
  output logic [7:0]       dbg_val
);
  typedef struct packed {
    logic [rie_pkg::PC_W-1:0] pc;
    logic [15:0]              ir;
    logic                     irv;
    logic                     ph;
    logic [7:0]               flags;
    logic [31:0][7:0]         rf;
    logic [5:0]               io_addr;
    logic                     io_re;
    logic                     io_we;
    logic [7:0]               io_wdata;
    logic [7:0]               dbg;
  } rie_core_st_t;

  rie_core_st_t         s_q;
  rie_core_st_t         s_d;
  rie_pkg::rie_fmt_rr_t f_rr;
  rie_pkg::rie_fmt_im_t f_im;
  rie_pkg::rie_fmt_bit_t f_bt;
  rie_pkg::rie_fmt_io_t f_io;
  rie_pkg::rie_fmt_br_t f_br;
  rie_pkg::rie_fmt_jp_t f_jp;
  rie_pkg::rie_fmt_io_t f_nx;
  rie_pkg::rie_major_t  maj;
  logic [7:0]           rd_v;
  logic [7:0]           rr_v;
  logic [7:0]           im_v;
  logic [7:0]           bt_v;
  logic [7:0]           io_v;
  rie_pkg::rie_alu_op_t alu_op;
  logic [7:0]           alu_a;
  logic [7:0]           alu_b;
  logic [7:0]           alu_res;
  logic [7:0]           alu_fl;
  logic                 hold;
  logic                 skip;
  logic                 jump;
  logic                 wen;
  logic [4:0]           wreg;
  logic [7:0]           wval;
  logic [7:0]           fmask;
  logic [8:0]           tgt;
  logic [7:0]           nb;
  logic                 fsel;

  // one word is one instruction, seen through every format
  // single word
  assign f_rr = s_q.ir;
  assign f_im = s_q.ir;
  assign f_bt = s_q.ir;
  assign f_io = s_q.ir;
  assign f_br = s_q.ir;
  assign f_jp = s_q.ir;
  assign f_nx = pm_data;
  assign maj  = f_rr.maj;

  // operand reads; immediate forms reach the upper sixteen
  assign rd_v = s_q.rf[f_rr.rd];
  assign rr_v = s_q.rf[f_rr.rr];
  assign im_v = s_q.rf[{1'b1, f_im.rd}];
  assign bt_v = s_q.rf[f_bt.rg];
  assign io_v = (f_io.addr == rie_pkg::IO_FLAGS) ? s_q.flags : io_rdata;

  // alu operand and operation select
  always_comb begin
    alu_op = rie_pkg::ALU_ADD;
    alu_a  = rd_v;
    alu_b  = rr_v;
    unique case (maj)
      rie_pkg::OP_RR: alu_op = rie_pkg::rie_alu_op_t'({1'b0, f_rr.mn});
      rie_pkg::OP_RR2: begin
        if (f_rr.mn == rie_pkg::RR2_OR) begin
          alu_op = rie_pkg::ALU_OR;
        end else begin
          alu_op = rie_pkg::ALU_AND;
        end
      end
      rie_pkg::OP_SUBI,
      rie_pkg::OP_CMP_IMM: begin
        alu_op = rie_pkg::ALU_SUB;
        alu_a  = im_v;
        alu_b  = f_im.k;
      end
      rie_pkg::OP_MCC: begin
        alu_op = rie_pkg::ALU_SBC;
        alu_a  = im_v;
        alu_b  = f_im.k;
      end
      rie_pkg::OP_CONJ,
      rie_pkg::OP_DISJ: begin
        alu_op = (maj == rie_pkg::OP_DISJ) ? rie_pkg::ALU_OR
                                           : rie_pkg::ALU_AND;
        alu_a  = im_v;
        alu_b  = f_im.k;
      end
      rie_pkg::OP_CLR_MASK: begin
        alu_op = rie_pkg::ALU_AND;
        alu_a  = im_v;
        alu_b  = rie_pkg::MASK_FF - f_im.k;
      end
      rie_pkg::OP_BIT: begin
        alu_a = bt_v;
        alu_b = bt_v;
        unique case (f_bt.bt)
          rie_pkg::UN_ROTATE_LEFT_CARRY:  alu_op = rie_pkg::ALU_ROL;
          rie_pkg::UN_ROTATE_RIGHT_CARRY: alu_op = rie_pkg::ALU_ROR;
          default:                        alu_op = rie_pkg::ALU_AND;
        endcase
      end
      default: alu_op = rie_pkg::ALU_ADD;
    endcase
  end

  rie_alu u_alu (
    .op  (alu_op),
    .a   (alu_a),
    .b   (alu_b),
    .cin (s_q.flags[rie_pkg::FC]),
    .res (alu_res),
    .fl  (alu_fl)
  );

  // execute the held word and fetch the next one
  always_comb begin
    s_d          = s_q;
    s_d.io_re    = 1'b0;
    s_d.io_we    = 1'b0;
    s_d.dbg      = s_q.rf[dbg_sel];
    hold         = 1'b0;
    skip         = 1'b0;
    jump         = 1'b0;
    wen          = 1'b0;
    wreg         = {1'b1, f_im.rd};
    wval         = alu_res;
    fmask        = 8'h00;
    nb           = io_v;
    tgt          = s_q.pc + {{2{f_br.k[6]}}, f_br.k};
    // signed ge/lt use n xor v
    fsel         = s_q.flags[f_br.sel];
    if (f_br.sel == rie_pkg::FS) begin
      fsel = s_q.flags[rie_pkg::FN] ^ s_q.flags[rie_pkg::FV];
    end
    if (s_q.irv) begin
      unique case (maj)
        rie_pkg::OP_RR: begin
          wen   = 1'b1;
          wreg  = f_rr.rd;
          fmask = rie_pkg::M_ARITH;
        end
        rie_pkg::OP_RR2: begin
          wreg = f_rr.rd;
          if (f_rr.mn == rie_pkg::RR2_CPSK) begin
            skip = (rd_v == rr_v);
          end else if (f_rr.mn == rie_pkg::RR2_AND ||
                       f_rr.mn == rie_pkg::RR2_OR) begin
            wen   = 1'b1;
            fmask = rie_pkg::M_LOGIC;
          end
        end
        rie_pkg::OP_SUBI,
        rie_pkg::OP_MCC: begin
          wen   = 1'b1;
          fmask = rie_pkg::M_ARITH;
        end
        rie_pkg::OP_CONJ,
        rie_pkg::OP_DISJ,
        rie_pkg::OP_CLR_MASK: begin
          wen   = 1'b1;
          fmask = rie_pkg::M_LOGIC;
        end
        rie_pkg::OP_CMP_IMM: fmask = rie_pkg::M_ARITH;
        rie_pkg::OP_BIT: begin
          wreg = f_bt.rg;
          unique case (f_bt.mn)
            rie_pkg::BT_SKIP_REG_BIT_CLEAR: skip = ~bt_v[f_bt.bt];
            rie_pkg::BT_SKIP_REG_BIT_SET:   skip = bt_v[f_bt.bt];
            rie_pkg::BT_STORE_BIT_TO_FLAG: begin
              s_d.flags[rie_pkg::FT] = bt_v[f_bt.bt];
            end
            rie_pkg::BT_LOAD_BIT_FROM_FLAG: begin
              wen           = 1'b1;
              wval          = bt_v;
              wval[f_bt.bt] = s_q.flags[rie_pkg::FT];
            end
            rie_pkg::BT_UNARY: begin
              if (f_bt.bt == rie_pkg::UN_ZERO_MINUS_CHECK) begin
                fmask = rie_pkg::M_LOGIC;
              end else if (f_bt.bt == rie_pkg::UN_ROTATE_LEFT_CARRY ||
                           f_bt.bt == rie_pkg::UN_ROTATE_RIGHT_CARRY) begin
                wen   = 1'b1;
                fmask = rie_pkg::M_ROT;
              end
            end
            rie_pkg::BT_FLAG_OP: begin
              s_d.flags[f_bt.bt] = f_bt.rg[0];
            end
            default: skip = 1'b0;
          endcase
        end
        rie_pkg::OP_IO: begin
          unique case (f_io.mn)
            rie_pkg::IO_SKIP_IO_BIT_CLEAR: skip = ~io_v[f_io.bt];
            rie_pkg::IO_SKIP_IO_BIT_SET:   skip = io_v[f_io.bt];
            rie_pkg::IO_SET_IO_BIT,
            rie_pkg::IO_CLEAR_IO_BIT: begin
              // write in the first cycle, stall one more
              if (!s_q.ph) begin
                hold        = 1'b1;
                nb[f_io.bt] = (f_io.mn == rie_pkg::IO_SET_IO_BIT);
                if (f_io.addr == rie_pkg::IO_FLAGS) begin
                  s_d.flags = nb;
                end else begin
                  s_d.io_we    = 1'b1;
                  s_d.io_wdata = nb;
                end
              end
            end
          endcase
        end
        rie_pkg::OP_BRF: jump = (fsel == f_br.set);
        rie_pkg::OP_LDI: begin
          wen  = 1'b1;
          wval = f_im.k;
        end
        rie_pkg::OP_RJMP: begin
          jump = 1'b1;
          tgt  = s_q.pc + f_jp.k[8:0];
        end
        default: jump = 1'b0;
      endcase
    end
    // masked flag merge, rules above pick the mask
    s_d.flags = (s_d.flags & ~fmask) | (alu_fl & fmask);
    if (wen) begin
      s_d.rf[wreg] = wval;
    end
    // sequencing: stall, redirect, drop the prefetch, or advance
    if (hold) begin
      s_d.ph = 1'b1;
    end else begin
      s_d.ph = 1'b0;
      if (jump) begin
        s_d.pc  = tgt;
        s_d.irv = 1'b0;
      end else if (skip) begin
        s_d.pc  = s_q.pc + 9'h001;
        s_d.irv = 1'b0;
      end else begin
        s_d.ir      = pm_data;
        s_d.irv     = 1'b1;
        s_d.pc      = s_q.pc + 9'h001;
        s_d.io_addr = f_nx.addr;
        s_d.io_re   = (f_nx.maj == rie_pkg::OP_IO) &&
                      (f_nx.addr != rie_pkg::IO_FLAGS);
      end
    end
  end

  // state register; reset starts with an empty pipeline
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_q       <= '0;
      s_q.pc    <= rie_pkg::PC_RST;
      s_q.flags <= rie_pkg::FLAGS_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign pm_addr   = s_q.pc;
  assign io_addr   = s_q.io_addr;
  assign io_re     = s_q.io_re;
  assign io_we     = s_q.io_we;
  assign io_wdata  = s_q.io_wdata;
  assign cpu_flags = s_q.flags;
  assign dbg_val   = s_q.dbg;

  // independent reference values for the checks below
  logic       ex_add;
  logic       ex_subi;
  logic       ex_logic;
  logic       ex_cbr;
  logic       ex_cpi;
  logic       ex_iow;
  logic       ex_bst;
  logic [8:0] chk_add;
  logic       chk_borrow;
  logic [7:0] chk_cbr;
  assign ex_add   = s_q.irv && maj == rie_pkg::OP_RR && f_rr.mn == 2'h0;
  assign ex_subi  = s_q.irv && maj == rie_pkg::OP_SUBI;
  assign ex_logic = s_q.irv && (maj == rie_pkg::OP_CONJ ||
                                maj == rie_pkg::OP_DISJ);
  assign ex_cbr   = s_q.irv && maj == rie_pkg::OP_CLR_MASK;
  assign ex_cpi   = s_q.irv && maj == rie_pkg::OP_CMP_IMM;
  assign ex_iow   = s_q.irv && maj == rie_pkg::OP_IO && f_io.mn[1];
  assign ex_bst   = s_q.irv && maj == rie_pkg::OP_BIT &&
                    f_bt.mn == rie_pkg::BT_STORE_BIT_TO_FLAG;
  assign chk_add    = {1'b0, rd_v} + {1'b0, rr_v};
  assign chk_borrow = im_v < f_im.k;
  assign chk_cbr    = im_v & ~f_im.k;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_ADD_RESULT: assert property (
    ex_add |=> s_q.rf[$past(f_rr.rd)] == $past(chk_add[7:0]) &&
               s_q.flags[rie_pkg::FC] == $past(chk_add[8]))
    else $error("add result or carry wrong");
  AST_SUBI_BORROW: assert property (
    ex_subi |=> s_q.flags[rie_pkg::FC] == $past(chk_borrow))
    else $error("subtract constant carry wrong");
  AST_LOGIC_KEEPS: assert property (
    ex_logic |=> $stable(s_q.flags[rie_pkg::FC]) &&
                 $stable(s_q.flags[rie_pkg::FH]) &&
                 !s_q.flags[rie_pkg::FV])
    else $error("logic op touched carry or half-carry");
  AST_CLR_MASK: assert property (
    ex_cbr |=> s_q.rf[{1'b1, $past(f_im.rd)}] == $past(chk_cbr))
    else $error("clear mask result wrong");
  AST_CMP_NO_WRITE: assert property (
    ex_cpi |=> s_q.rf == $past(s_q.rf))
    else $error("compare immediate wrote a register");
  AST_SKIP_BUBBLE: assert property (
    s_q.irv && skip |=> !s_q.irv ##1 s_q.irv)
    else $error("skip did not cost exactly one bubble");
  AST_BRANCH_TARGET: assert property (
    s_q.irv && maj == rie_pkg::OP_BRF && jump
      |=> s_q.pc == $past(tgt) && !s_q.irv)
    else $error("taken branch went to wrong target");
  AST_IO_TWO_CYCLE: assert property (
    ex_iow && !s_q.ph |=> s_q.ph && $stable(s_q.ir) ##1 !s_q.ph)
    else $error("i/o bit write not two cycles");
  AST_IO_FLAGS_KEPT: assert property (
    ex_iow && !s_q.ph && f_io.addr != rie_pkg::IO_FLAGS
      |=> $stable(s_q.flags) [*2])
    else $error("i/o bit write changed flags");
  AST_STORE_BIT: assert property (
    ex_bst |=> s_q.flags[rie_pkg::FT] == $past(bt_v[f_bt.bt]) &&
               s_q.flags[5:0] == $past(s_q.flags[5:0]))
    else $error("bit store wrong or disturbed flags");

  COV_SKIP: cover property (s_q.irv && skip);
  COV_BRANCH: cover property (s_q.irv && maj == rie_pkg::OP_BRF && jump);
  COV_IO_WRITE: cover property (s_q.io_we);
  COV_ADD: cover property (ex_add);
endmodule

// file: rie_mem.sv
`timescale 1ns/1ps
// program memory and i/o register space facing the execute core
module rie_mem (
  // clock
  input  wire logic        clk,
  // program fetch
  input  wire logic [8:0]  pm_addr,
  output logic [15:0]      pm_data,
  // i/o register space
  input  wire logic [5:0]  io_addr,
  input  wire logic        io_re,
  input  wire logic        io_we,
  input  wire logic [7:0]  io_wdata,
  output logic [7:0]       io_rdata
);
  logic [15:0] rom [512];
  logic [7:0]  io [64];
  logic [7:0]  last_q = 8'ha5;

  assign pm_data = rom[pm_addr];
  // bus not strobed: inverse of last byte, so stale data never passes
  assign io_rdata = io_re ? io[io_addr] : ~last_q;

  // writes land at the edge closing the strobe cycle
  always @(posedge clk) begin
    if (io_re)
      last_q <= io[io_addr];
    if (io_we)
      io[io_addr] <= io_wdata;
  end
endmodule

// file: tb_risc8_instruction_execute.sv
`timescale 1ns/1ps
// self-checking bench for the risc8 execute core
module tb_risc8_instruction_execute;
  logic        clk;
  logic        resetn;
  logic [8:0]  pm_addr;
  logic [15:0] pm_data;
  logic [5:0]  io_addr;
  logic        io_re;
  logic        io_we;
  logic [7:0]  io_wdata;
  logic [7:0]  io_rdata;
  logic [7:0]  cpu_flags;
  logic [4:0]  dbg_sel;
  logic [7:0]  dbg_val;
  logic        pv;
  logic        pv_d;
  logic        re_d;
  logic [8:0]  re_e;
  logic [14:0] ie;
  int          error_cnt;
  int          n_checks;
  int          cyc;
  logic [15:0] pq[$];
  logic [8:0]  rq[$];
  logic [14:0] iq[$];

  rie_core uut (.clk(clk), .resetn(resetn), .pm_addr(pm_addr),
    .pm_data(pm_data), .io_addr(io_addr), .io_re(io_re), .io_we(io_we),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .cpu_flags(cpu_flags),
    .dbg_sel(dbg_sel), .dbg_val(dbg_val));
  rie_mem mem (.clk(clk), .pm_addr(pm_addr), .pm_data(pm_data),
    .io_addr(io_addr), .io_re(io_re), .io_we(io_we),
    .io_wdata(io_wdata), .io_rdata(io_rdata));

  // 25 ns bench clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [15:0] arith(logic [7:0] a, logic [7:0] b,
                                        logic ci, logic sb);
    logic [8:0] r;
    logic [4:0] h;
    logic       v;
    r = sb ? {1'b0, a} - {1'b0, b} - {8'h00, ci}
           : {1'b0, a} + {1'b0, b} + {8'h00, ci};
    h = sb ? {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci}
           : {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    v = (a[7] ^ r[7]) & (sb ? a[7] ^ b[7] : a[7] ~^ b[7]);
    return {2'b00, h[4], r[7] ^ v, v, r[7], r[7:0] == 8'h00, r[8], r[7:0]};
  endfunction

  // logic ops keep carry and half-carry, clear overflow
  function automatic logic [7:0] lgc(logic [7:0] r, logic c);
    return {3'h0, r[7], 1'b0, r[7], r == 8'h00, c};
  endfunction

  function automatic logic [15:0] ldi(logic [3:0] r, logic [7:0] k);
    return {4'hb, r, k};
  endfunction

  function automatic logic [15:0] fop(logic [2:0] i, logic s);
    return {4'h8, 3'h5, 1'b0, 4'h0, s, i};
  endfunction

  task automatic final_report();
    if (error_cnt == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // note a register or flag view; caller lowers pv after the last one
  task automatic probe(logic [4:0] s, logic f, logic [7:0] e);
    rq.push_back({f, e});
    dbg_sel <= s;
    pv      <= 1'b1;
    @(posedge clk);
  endtask

  // reset, load the program, run until the fetch passes its end
  task automatic run();
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 512; i++)
      mem.rom[i] = i < pq.size() ? pq[i] : 16'hcfff;
    resetn <= 1'b1;
    for (int n = 0; n < 100 && pm_addr !== 9'(pq.size()); n++)
      @(posedge clk);
    repeat (4) @(posedge clk);
  endtask

  task automatic t_alu(int op);
    logic [7:0]  a, b, r, f;
    logic [15:0] w;
    logic        ci, t;
    a  = 8'($urandom);
    b  = 8'($urandom);
    ci = 1'($urandom);
    pq = {ldi(4'h0, a), ldi(4'h1, b), fop(3'h0, ci)};
    r  = a;
    f  = {7'h00, ci};
    case (op)
      0, 1, 2, 3: begin
        w = {4'h0, 2'(op), 5'd16, 5'd17};
        {f, r} = arith(a, b, op[0] & ci, op[1]);
      end
      4, 5: begin
        w = {4'h1, 2'(op - 4), 5'd16, 5'd17};
        r = op[0] ? a | b : a & b;
        f = lgc(r, ci);
      end
      6, 7, 11: begin
        w = {4'(op - 4), 4'h0, b};
        {f, r} = arith(a, b, op == 7 && ci, 1'b1);
        if (op == 11)
          r = a;
      end
      8, 9, 10: begin
        w = {4'(op - 4), 4'h0, b};
        r = op == 8 ? a & b : op == 9 ? a | b : a & (8'hff - b);
        f = lgc(r, ci);
      end
      12: begin
        w = {4'h8, 3'h4, 1'b0, 5'd16, 3'h2};
        f = lgc(a, ci);
      end
      13, 14: begin
        w = {4'h8, 3'h4, 1'b0, 5'd16, 3'(op - 13)};
        {t, r} = op == 13 ? {a, ci} : {a[0], ci, a[7:1]};
        f = {3'h0, t, r[7] ^ t, r[7], r == 8'h00, t};
      end
      15: begin
        w = {4'h8, 3'h2, 1'b0, 5'd16, b[2:0]};
        f[6] = a[b[2:0]];
      end
      default: begin
        pq.push_back({4'h8, 3'h2, 1'b0, 5'd17, b[2:0]});
        w = {4'h8, 3'h3, 1'b0, 5'd16, b[5:3]};
        f[6] = b[b[2:0]];
        r[b[5:3]] = f[6];
      end
    endcase
    pq.push_back(w);
    run();
    probe(5'd16, 1'b0, r);
    probe(5'd17, 1'b0, b);
    probe(5'd0, 1'b1, f);
    pv <= 1'b0;
  endtask

  task automatic t_skip(int k);
    logic [7:0] a, b, v;
    logic [5:0] p;
    logic [2:0] bt;
    logic       sk;
    a  = 8'($urandom);
    b  = $urandom_range(1) ? a : a ^ 8'h01;
    v  = 8'($urandom);
    p  = 6'($urandom_range(62));
    bt = 3'($urandom);
    mem.io[p] = v;
    pq = {ldi(4'h0, a), ldi(4'h1, b)};
    sk = 1'b0;
    if (k == 0) begin
      pq.push_back({4'h1, 2'h2, 5'd16, 5'd17});
      sk = a == b;
    end else if (k < 3) begin
      pq.push_back({4'h8, 3'(k - 1), 1'b0, 5'd16, bt});
      sk = a[bt] == k[1];
    end else begin
      pq.push_back({4'h9, 2'(k - 3), 1'b0, p, bt});
      if (k < 5)
        sk = v[bt] == (k == 4);
      else
        iq.push_back({p, k == 5 ? v | (8'h01 << bt) : v & ~(8'h01 << bt),
                      1'b1});
    end
    pq.push_back(ldi(4'h2, 8'h01));
    pq.push_back(ldi(4'h3, 8'h02));
    run();
    probe(5'd18, 1'b0, sk ? 8'h00 : 8'h01);
    probe(5'd19, 1'b0, 8'h02);
    probe(5'd0, 1'b1, 8'h00);
    pv <= 1'b0;
  endtask

  task automatic t_br(logic [2:0] sel, logic s);
    logic [7:0] fl;
    logic       tk;
    fl = 8'($urandom);
    pq = {16'hc002, ldi(4'h3, 8'h02), 16'hcfff};
    for (int i = 0; i < 8; i++)
      pq.push_back(fop(3'(i), fl[i]));
    // backward offset from 11 to 1
    pq.push_back({4'ha, 1'b0, s, 7'h75, sel});
    pq.push_back(ldi(4'h2, 8'h01));
    tk = (sel == 3'h4 ? fl[2] ^ fl[3] : fl[sel]) == s;
    run();
    probe(5'd18, 1'b0, tk ? 8'h00 : 8'h01);
    probe(5'd19, 1'b0, tk ? 8'h02 : 8'h00);
    probe(5'd0, 1'b1, fl);
    pv <= 1'b0;
  endtask

  // delay the probe flag by the view latency, remember the read strobe
  always @(posedge clk) begin
    pv_d <= pv;
    re_d <= io_re;
  end

  // take the oldest note whenever a view or an i/o write shows up
  always @(negedge clk) begin
    if (pv_d) begin
      re_e = rq.pop_front();
      chk(re_e[8] ? "cpu_flags" : "dbg_val", 16'(re_e[7:0]),
          16'(re_e[8] ? cpu_flags : dbg_val));
    end
    if (resetn && io_we) begin
      ie = iq.pop_front();
      chk("io_write", 16'(ie), 16'({io_addr, io_wdata, re_d}));
    end
  end

  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      error_cnt++;
      final_report();
    end
  end

  initial begin
    resetn    = 1'b0;
    dbg_sel   = 5'h00;
    pv        = 1'b0;
    pv_d      = 1'b0;
    re_d      = 1'b0;
    error_cnt = 0;
    n_checks  = 0;
    cyc       = 0;
    void'($urandom(32'haf49a91f));
    @(posedge clk);
    for (int r = 0; r < 3; r++) begin
      for (int op = 0; op < 17; op++)
        t_alu(op);
      for (int k = 0; k < 7; k++)
        t_skip(k);
    end
    for (int i = 0; i < 16; i++)
      t_br(3'(i), 1'(i >> 3));
    final_report();
  end
endmodule
